/* inc/nvm_port_pkg.sv */
// Constants, codes and carriers for the parallel non-volatile programming port.
// Assumes one 125 MHz system clock; all programmer pins are asynchronous to it.
package nvm_port_pkg;

    // ------------------------------------------------------------
    // Pin carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] action_select;  // {action_select_hi, action_select_lo}
        logic [1:0] byte_select;    // {byte_select_hi, byte_select_lo}
        logic oe_n;
        logic wr_n;
        logic load_strobe;
        logic page_latch_strobe;
        logic [7:0] data;
    } prog_pins_s;

    // ------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD = 2'h2;

    localparam logic [1:0] BSEL_LOW = 2'h0;
    localparam logic [1:0] BSEL_HIGH = 2'h1;
    localparam logic [1:0] BSEL_EXT = 2'h2;
    localparam logic [1:0] BSEL_FUSE_HIGH_RD = 2'h3;

    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_WRITE_FUSE = 8'h40;
    localparam logic [7:0] CMD_WRITE_LOCK = 8'h20;
    localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;
    localparam logic [7:0] CMD_WRITE_EEPROM = 8'h11;
    localparam logic [7:0] CMD_READ_SIG = 8'h08;
    localparam logic [7:0] CMD_READ_FUSE_LOCK = 8'h04;
    localparam logic [7:0] CMD_READ_FLASH = 8'h02;
    localparam logic [7:0] CMD_READ_EEPROM = 8'h03;

    // ------------------------------------------------------------
    // Values and fields
    // ------------------------------------------------------------
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    localparam logic [7:0] SIG_FIRST_ADDR = 8'h00;
    localparam logic [7:0] SIG_MID_ADDR = 8'h01;
    localparam logic [7:0] SIG_LAST_ADDR = 8'h02;
    localparam logic [7:0] CALIB_ADDR = 8'h00;
    localparam int LOCK_A_BIT = 0;
    localparam int LOCK_B_BIT = 1;
    localparam logic [7:0] BOOT_LOCK_MASK = 8'h3c;
    localparam logic [7:0] FUSE_LOW_RESET = 8'h62;
    localparam logic [7:0] FUSE_HIGH_RESET = 8'h99;
    localparam logic [7:0] FUSE_EXT_RESET = 8'hff;
    localparam logic [7:0] LOCK_RESET = 8'hff;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int WRITE_TIME_NS = 3700000;
    localparam int PROG_CYCLES_DEF = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_DRAIN = 3'b010,
        PH_PROG = 3'b100
    } phase_e;

endpackage

/* core/nvm_program_port.sv */
// Parallel programming port: strobe decoding, page buffer, arrays, fuses and lock bits.
// Assumes every programmer pin is asynchronous and slow against the 125 MHz clock.
// Functional notes
// - Command byte loads on load strobe.
// - 0x10 writes Flash page buffer and array.
// - Address action, select 00 loads bits 7..0.
// - Address action, select 01 loads bits 15..8.
// - Address action, select 10 loads bits 23..16.
// - Data action loads low or high byte.
// - Page latch stores word at address.
// - Low bits word, high bits page.
// - Write pulse programs Flash page, busy low.
// - Command 0x00 cancels a draining page write while words are still queued, clears nothing; in the commit cycle the page is still written.
// - 0x11 programs EEPROM page while busy.
// - Flash read drives low or high byte.
// - EEPROM read drives addressed byte.
// - Fuse write: 0 programs, 1 erases.
// - Byte select picks fuse low/high/extended.
// - Lock mode 3 blocks boot lock bits.
// - Programmed lock bits never revert.
// - Fuse and lock read by select.
// - Signature byte read at address 0..2.
// - Calibration byte read with select 1.
// - Ready flag low while busy.
// - Data bus driven only while enabled.
// - Command and address are retained.
`timescale 1ns/1ps

// ------------------------------------------------------------
// Entry FIFO
// ------------------------------------------------------------
module nvm_entry_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] count;
    } fifo_s;

    fifo_s st;
    fifo_s next_st;
    logic push;
    logic pop;

    assign in_ready = (st.count != (AW+1)'(DEPTH));
    assign out_valid = (st.count != '0);
    assign out_data = st.mem[st.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wp] = in_data;
            next_st.wp = (st.wp == AW'(DEPTH - 1)) ? '0 : st.wp + 1'b1;
        end
        if (pop) begin
            next_st.rp = (st.rp == AW'(DEPTH - 1)) ? '0 : st.rp + 1'b1;
        end
        next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// ------------------------------------------------------------
// Programming port
// ------------------------------------------------------------
module nvm_program_port
    import nvm_port_pkg::*;
#(
    parameter int FLASH_AW = 13,
    parameter int PAGE_AW = 6,
    parameter int EE_AW = 9,
    parameter int EE_PAGE_AW = 2,
    parameter int FIFO_DEPTH = 8,
    parameter int PROG_CYCLES = PROG_CYCLES_DEF,
    parameter logic [7:0] SIG_BYTE0 = 8'h5a,  // Arbitrary value.
    parameter logic [7:0] SIG_BYTE1 = 8'h3c,  // Arbitrary value.
    parameter logic [7:0] SIG_BYTE2 = 8'h0f,  // Arbitrary value.
    parameter logic [7:0] CALIB_BYTE = 8'h80
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire prog_pins_s pins,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic done_flag,
    output logic [7:0] fuse_low,
    output logic [7:0] fuse_high,
    output logic [7:0] fuse_ext,
    output logic [7:0] lock_bits
);
    localparam int FLASH_WORDS = 1 << FLASH_AW;
    localparam int PAGE_WORDS = 1 << PAGE_AW;
    localparam int EE_BYTES = 1 << EE_AW;
    localparam int EE_PAGE_BYTES = 1 << EE_PAGE_AW;
    localparam int CW = $clog2(PROG_CYCLES + 1);
    localparam int EW = PAGE_AW + 16;

    typedef struct packed {
        prog_pins_s p1;
        prog_pins_s p2;
        prog_pins_s p3;
        logic [7:0] cmd;
        logic [23:0] addr;
        logic [7:0] dlo;
        logic [7:0] dhi;
        logic pend_valid;
        logic [EW-1:0] pend;
        phase_e phase;
        logic [CW-1:0] cnt;
        logic tgt_ee;
        logic [PAGE_WORDS-1:0][15:0] pbuf;
        logic [FLASH_WORDS-1:0][15:0] flash;
        logic [EE_BYTES-1:0][7:0] eeprom;
        logic [7:0] fuse_lo;
        logic [7:0] fuse_hi;
        logic [7:0] fuse_ex;
        logic [7:0] lock;
        logic [7:0] dout;
        logic doe;
        logic done;
    } port_s;

    port_s st;
    port_s next_st;
    logic ld_rise;
    logic pl_rise;
    logic wr_fall;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [EW-1:0] fifo_out_data;

    function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic hi);
        pick_byte = hi ? w[15:8] : w[7:0];
    endfunction

    // Edges come from the second and third stage only, never the first.
    assign ld_rise = st.p2.load_strobe && !st.p3.load_strobe;
    assign pl_rise = st.p2.page_latch_strobe && !st.p3.page_latch_strobe;
    assign wr_fall = !st.p2.wr_n && st.p3.wr_n;
    // The page buffer is frozen while it is being committed.
    assign fifo_out_ready = (st.phase != PH_PROG);

    nvm_entry_fifo #(
        .WIDTH(EW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(st.pend_valid),
        .in_ready(fifo_in_ready),
        .in_data(st.pend),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    always_comb begin
        logic [7:0] rd;
        logic [FLASH_AW-PAGE_AW-1:0] fpage;
        logic [EE_AW-EE_PAGE_AW-1:0] epage;
        rd = ERASED_BYTE;
        fpage = st.addr[FLASH_AW-1:PAGE_AW];
        epage = st.addr[EE_AW-1:EE_PAGE_AW];
        next_st = st;
        next_st.p1 = pins;
        next_st.p2 = st.p1;
        next_st.p3 = st.p2;

        // ------------------------------------------------------------
        // Load strobe decoding
        // ------------------------------------------------------------
        if (ld_rise) begin
            case (st.p2.action_select)
                ACT_CMD: begin
                    if (!st.p2.byte_select[0]) begin
                        next_st.cmd = st.p2.data;
                    end
                end
                ACT_ADDR: begin
                    case (st.p2.byte_select)
                        BSEL_LOW: next_st.addr[7:0] = st.p2.data;
                        BSEL_HIGH: next_st.addr[15:8] = st.p2.data;
                        BSEL_EXT: next_st.addr[23:16] = st.p2.data;
                        default: next_st.addr = st.addr;
                    endcase
                end
                ACT_DATA: begin
                    if (st.p2.byte_select[0]) begin
                        next_st.dhi = st.p2.data;
                    end else begin
                        next_st.dlo = st.p2.data;
                    end
                end
                default: next_st.cmd = st.cmd;
            endcase
        end

        // ------------------------------------------------------------
        // Page latch into the entry FIFO
        // ------------------------------------------------------------
        if (st.pend_valid && fifo_in_ready) begin
            next_st.pend_valid = 1'b0;
        end
        if (pl_rise && st.p2.byte_select[0]
                && (st.cmd == CMD_WRITE_FLASH || st.cmd == CMD_WRITE_EEPROM)) begin
            next_st.pend_valid = 1'b1;
            if (st.cmd == CMD_WRITE_EEPROM) begin
                next_st.pend = {PAGE_AW'(st.addr[EE_PAGE_AW-1:0]), st.dhi, st.dlo};
            end else begin
                next_st.pend = {st.addr[PAGE_AW-1:0], st.dhi, st.dlo};
            end
        end
        if (fifo_out_valid && fifo_out_ready) begin
            next_st.pbuf[fifo_out_data[EW-1:16]] = fifo_out_data[15:0];
        end

        // ------------------------------------------------------------
        // Write pulse and programming sequence
        // ------------------------------------------------------------
        case (st.phase)
            PH_IDLE: begin
                if (wr_fall) begin
                    case (st.cmd)
                        CMD_WRITE_FLASH, CMD_WRITE_EEPROM: begin
                            // Page write starts on write pulse
                            if (st.p2.byte_select == BSEL_LOW) begin
                                next_st.tgt_ee = (st.cmd == CMD_WRITE_EEPROM);
                                next_st.phase = PH_DRAIN;
                            end
                        end
                        CMD_WRITE_FUSE: begin
                            next_st.phase = PH_PROG;
                            next_st.cnt = CW'(PROG_CYCLES - 1);
                            case (st.p2.byte_select)
                                BSEL_LOW: next_st.fuse_lo = st.dlo;
                                BSEL_HIGH: next_st.fuse_hi = st.dlo;
                                BSEL_EXT: next_st.fuse_ex = st.dlo;
                                default: next_st.phase = PH_IDLE;
                            endcase
                        end
                        CMD_WRITE_LOCK: begin
                            next_st.phase = PH_PROG;
                            next_st.cnt = CW'(PROG_CYCLES - 1);
                            next_st.lock = st.lock & st.dlo;
                            // Mode 3 freezes boot lock bits
                            if (!st.lock[LOCK_A_BIT] && !st.lock[LOCK_B_BIT]) begin
                                next_st.lock = (st.lock & st.dlo & ~BOOT_LOCK_MASK)
                                    | (st.lock & BOOT_LOCK_MASK);
                            end
                        end
                        default: next_st.phase = PH_IDLE;
                    endcase
                end
            end
            PH_DRAIN: begin
                // Commit only after every latched word has reached the buffer.
                if (!st.pend_valid && !fifo_out_valid) begin
                    next_st.phase = PH_PROG;
                    next_st.cnt = CW'(PROG_CYCLES - 1);
                    if (st.tgt_ee) begin
                        for (int i = 0; i < EE_PAGE_BYTES; i++) begin
                            next_st.eeprom[{epage, EE_PAGE_AW'(i)}] = st.pbuf[i][7:0];
                        end
                    end else begin
                        // Flash page from high address bits
                        for (int i = 0; i < PAGE_WORDS; i++) begin
                            next_st.flash[{fpage, PAGE_AW'(i)}] = st.pbuf[i];
                        end
                    end
                    for (int i = 0; i < PAGE_WORDS; i++) begin
                        next_st.pbuf[i] = ERASED_WORD;
                    end
                end
            end
            PH_PROG: begin
                if (st.cnt == '0) begin
                    next_st.phase = PH_IDLE;
                end else begin
                    next_st.cnt = st.cnt - 1'b1;
                end
            end
            default: next_st.phase = PH_IDLE;
        endcase

        // No-operation cancels a pending page write unless it commits in this cycle
        if (st.cmd == CMD_NOP && st.phase == PH_DRAIN) begin
            next_st.phase = PH_IDLE;
        end
        next_st.done = (next_st.phase == PH_IDLE);

        // ------------------------------------------------------------
        // Read path
        // ------------------------------------------------------------
        case (st.cmd)
            CMD_READ_FLASH: rd = pick_byte(st.flash[st.addr[FLASH_AW-1:0]],
                st.p2.byte_select[0]);
            CMD_READ_EEPROM: begin
                if (!st.p2.byte_select[0]) begin
                    rd = st.eeprom[st.addr[EE_AW-1:0]];
                end
            end
            CMD_READ_FUSE_LOCK: begin
                case (st.p2.byte_select)
                    BSEL_LOW: rd = st.fuse_lo;
                    BSEL_FUSE_HIGH_RD: rd = st.fuse_hi;
                    BSEL_EXT: rd = st.fuse_ex;
                    default: rd = st.lock;
                endcase
            end
            CMD_READ_SIG: begin
                if (st.p2.byte_select[0]) begin
                    if (st.addr[7:0] == CALIB_ADDR) begin
                        rd = CALIB_BYTE;
                    end
                end else begin
                    case (st.addr[7:0])
                        SIG_FIRST_ADDR: rd = SIG_BYTE0;
                        SIG_MID_ADDR: rd = SIG_BYTE1;
                        SIG_LAST_ADDR: rd = SIG_BYTE2;
                        default: rd = ERASED_BYTE;
                    endcase
                end
            end
            default: rd = ERASED_BYTE;
        endcase
        next_st.dout = rd;
        // Drive only while enable is low
        next_st.doe = !st.p2.oe_n;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '0;
            st.p1.oe_n <= 1'b1;
            st.p2.oe_n <= 1'b1;
            st.p3.oe_n <= 1'b1;
            st.p1.wr_n <= 1'b1;
            st.p2.wr_n <= 1'b1;
            st.p3.wr_n <= 1'b1;
            st.phase <= PH_IDLE;
            st.done <= 1'b1;
            st.dout <= ERASED_BYTE;
            st.pbuf <= '1;
            st.flash <= '1;
            st.eeprom <= '1;
            st.fuse_lo <= FUSE_LOW_RESET;
            st.fuse_hi <= FUSE_HIGH_RESET;
            st.fuse_ex <= FUSE_EXT_RESET;
            st.lock <= LOCK_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign data_out = st.dout;
    assign data_oe = st.doe;
    assign done_flag = st.done;
    assign fuse_low = st.fuse_lo;
    assign fuse_high = st.fuse_hi;
    assign fuse_ext = st.fuse_ex;
    assign lock_bits = st.lock;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_cmd_load;
        @(posedge clk) disable iff (sys_rst)
        ld_rise && st.p2.action_select == ACT_CMD && !st.p2.byte_select[0]
            |=> st.cmd == $past(st.p2.data);
    endproperty
    a_cmd_load: assert property (p_cmd_load) else $error("command not captured");

    property p_addr_low;
        @(posedge clk) disable iff (sys_rst)
        ld_rise && st.p2.action_select == ACT_ADDR && st.p2.byte_select == BSEL_LOW
            |=> st.addr[7:0] == $past(st.p2.data) && $stable(st.addr[23:8]);
    endproperty
    a_addr_low: assert property (p_addr_low) else $error("address low wrong");

    property p_addr_high;
        @(posedge clk) disable iff (sys_rst)
        ld_rise && st.p2.action_select == ACT_ADDR && st.p2.byte_select == BSEL_HIGH
            |=> st.addr[15:8] == $past(st.p2.data) && $stable(st.addr[7:0]);
    endproperty
    a_addr_high: assert property (p_addr_high) else $error("address high wrong");

    property p_addr_ext;
        @(posedge clk) disable iff (sys_rst)
        ld_rise && st.p2.action_select == ACT_ADDR && st.p2.byte_select == BSEL_EXT
            |=> st.addr[23:16] == $past(st.p2.data);
    endproperty
    a_addr_ext: assert property (p_addr_ext) else $error("address extended wrong");

    property p_data_hi;
        @(posedge clk) disable iff (sys_rst)
        ld_rise && st.p2.action_select == ACT_DATA && st.p2.byte_select[0]
            |=> st.dhi == $past(st.p2.data) && $stable(st.dlo);
    endproperty
    a_data_hi: assert property (p_data_hi) else $error("data high wrong");

    property p_busy;
        @(posedge clk) disable iff (sys_rst)
        st.phase == PH_IDLE && wr_fall && st.cmd == CMD_WRITE_LOCK
            |=> !done_flag [*2];
    endproperty
    a_busy: assert property (p_busy) else $error("ready not low on write");

    property p_oe;
        @(posedge clk) disable iff (sys_rst)
        data_oe == !$past(pins.oe_n, 3);
    endproperty
    a_oe: assert property (p_oe) else $error("bus driven without enable");

    property p_lock_keep;
        @(posedge clk) disable iff (sys_rst)
        ##1 (st.lock & ~$past(st.lock)) == 8'h00;
    endproperty
    a_lock_keep: assert property (p_lock_keep) else $error("lock bit reverted");

    property p_cmd_hold;
        @(posedge clk) disable iff (sys_rst)
        !(ld_rise && st.p2.action_select == ACT_CMD) |=> $stable(st.cmd);
    endproperty
    a_cmd_hold: assert property (p_cmd_hold) else $error("command changed");

    property p_flash_rd;
        @(posedge clk) disable iff (sys_rst)
        st.cmd == CMD_READ_FLASH && !st.p2.byte_select[0]
            |=> data_out == $past(st.flash[st.addr[FLASH_AW-1:0]][7:0]);
    endproperty
    a_flash_rd: assert property (p_flash_rd) else $error("flash read wrong");
endmodule

/* tb/nvm_programmer.sv */
// Behavioural parallel programmer that drives every pin of the port.
// Assumes the port's clock; pins change only on falling edges, held for several cycles.
`timescale 1ns/1ps
module nvm_programmer
    import nvm_port_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] data_out,
    input wire logic done_flag,
    input wire logic data_oe,
    output prog_pins_s pins
);
    initial begin
        pins = {2'h3, 2'h0, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00};
    end
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic ld(input logic [1:0] a, input logic [1:0] b, input logic [7:0] d);
        pins.action_select = a;
        pins.byte_select = b;
        pins.data = d;
        step(4);
        pins.load_strobe = 1'b1;
        step(6);
        pins.load_strobe = 1'b0;
        step(6);
        pins.action_select = 2'h3;
        // A released bus shows the inverse so a stale value cannot pass.
        pins.data = ~d;
        // Let an edge pass so a following load never reassigns in this step.
        step(1);
    endtask
    task automatic pl();
        pins.byte_select = 2'h1;
        step(4);
        pins.page_latch_strobe = 1'b1;
        step(6);
        pins.page_latch_strobe = 1'b0;
        step(6);
    endtask
    task automatic wr(input logic [1:0] b, output logic busy);
        pins.byte_select = b;
        step(4);
        pins.wr_n = 1'b0;
        step(6);
        busy = done_flag;
        pins.wr_n = 1'b1;
        // A stuck busy flag is caught by the bench's cycle ceiling.
        while (done_flag !== 1'b1) step(1);
        step(4);
    endtask
    task automatic rd(input logic [1:0] b, output logic [7:0] v);
        pins.byte_select = b;
        pins.oe_n = 1'b0;
        step(8);
        // An undriven bus reads as the inverse, so a missing enable shows.
        v = data_oe ? data_out : ~data_out;
        pins.oe_n = 1'b1;
        step(6);
    endtask
endmodule

/* tb/tb_top.sv */
// Testbench for the parallel programming port, with the programmer model on its pins.
// Assumes small arrays and a short programming count for speed.
`timescale 1ns/1ps
module tb_top
    import nvm_port_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    prog_pins_s pins;
    logic [7:0] data_out, fuse_low, fuse_high, fuse_ext, lock_bits;
    logic data_oe, done_flag;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    nvm_program_port #(.FLASH_AW(8), .PAGE_AW(3), .EE_AW(5), .EE_PAGE_AW(2),
        .PROG_CYCLES(16)) dut (.clk(clk), .sys_rst(sys_rst), .pins(pins),
        .data_out(data_out), .data_oe(data_oe), .done_flag(done_flag), .fuse_low(fuse_low),
        .fuse_high(fuse_high), .fuse_ext(fuse_ext), .lock_bits(lock_bits));
    nvm_programmer prog (.clk(clk), .data_out(data_out), .data_oe(data_oe),
        .done_flag(done_flag), .pins(pins));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // The run here should take about 1700 cycles; the ceiling leaves wide margin.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end
    task automatic t_flash();
        logic [7:0] v;
        logic b;
        prog.ld(ACT_CMD, 2'h0, CMD_WRITE_FLASH);
        prog.ld(ACT_ADDR, BSEL_HIGH, 8'h00);
        prog.ld(ACT_ADDR, BSEL_EXT, 8'h00);
        for (int i = 0; i < 8; i++) begin
            prog.ld(ACT_ADDR, BSEL_LOW, 8'h08 + i[7:0]);
            prog.ld(ACT_DATA, 2'h0, i[7:0]);
            prog.ld(ACT_DATA, 2'h1, 8'ha0 + i[7:0]);
            prog.pl();
        end
        prog.wr(BSEL_LOW, b);
        chk("flash busy", {7'h0, b}, 8'h00);
        chk("flash ready", {7'h0, done_flag}, 8'h01);
        prog.ld(ACT_CMD, 2'h0, CMD_NOP);
        prog.wr(BSEL_LOW, b);
        chk("nop write ignored", {7'h0, b}, 8'h01);
        prog.ld(ACT_CMD, 2'h0, CMD_READ_FLASH);
        for (int i = 0; i < 8; i++) begin
            prog.ld(ACT_ADDR, BSEL_LOW, 8'h08 + i[7:0]);
            prog.rd(2'h0, v);
            chk("flash low", v, i[7:0]);
            prog.rd(2'h1, v);
            chk("flash high", v, 8'ha0 + i[7:0]);
        end
        prog.ld(ACT_ADDR, BSEL_LOW, 8'h00);
        prog.rd(2'h0, v);
        chk("other page", v, ERASED_BYTE);
        chk("bus released", {7'h0, data_oe}, 8'h00);
        $display("test flash done");
    endtask
    task automatic t_ee();
        logic [7:0] v;
        logic b;
        prog.ld(ACT_CMD, 2'h0, CMD_WRITE_EEPROM);
        prog.ld(ACT_ADDR, BSEL_LOW, 8'h05);
        prog.ld(ACT_DATA, 2'h0, 8'h77);
        prog.pl();
        prog.wr(BSEL_LOW, b);
        chk("eeprom busy", {7'h0, b}, 8'h00);
        prog.ld(ACT_CMD, 2'h0, CMD_READ_EEPROM);
        prog.rd(2'h0, v);
        chk("eeprom read", v, 8'h77);
        $display("test eeprom done");
    endtask
    task automatic t_fuse();
        logic [7:0] v;
        logic b;
        logic [7:0] val [3] = '{8'h12, 8'h34, 8'h56};
        prog.ld(ACT_CMD, 2'h0, CMD_WRITE_FUSE);
        for (int i = 0; i < 4; i++) begin
            prog.ld(ACT_DATA, 2'h0, i < 3 ? val[i] : 8'h00);
            prog.wr(i[1:0], b);
        end
        chk("fuse low", fuse_low, 8'h12);
        chk("fuse high", fuse_high, 8'h34);
        chk("fuse ext", fuse_ext, 8'h56);
        prog.ld(ACT_CMD, 2'h0, CMD_READ_FUSE_LOCK);
        prog.rd(BSEL_FUSE_HIGH_RD, v);
        chk("read high", v, 8'h34);
        prog.rd(BSEL_EXT, v);
        chk("read ext", v, 8'h56);
        prog.rd(BSEL_LOW, v);
        chk("read low", v, 8'h12);
        $display("test fuse done");
    endtask
    task automatic t_lock();
        logic [7:0] v;
        logic b;
        prog.ld(ACT_CMD, 2'h0, CMD_WRITE_LOCK);
        prog.ld(ACT_DATA, 2'h0, 8'hfc);
        prog.wr(BSEL_LOW, b);
        chk("lock mode 3", lock_bits, 8'hfc);
        prog.ld(ACT_DATA, 2'h0, 8'hc3);
        prog.wr(BSEL_LOW, b);
        chk("lock kept", lock_bits, 8'hfc);
        prog.ld(ACT_CMD, 2'h0, CMD_READ_FUSE_LOCK);
        prog.rd(BSEL_HIGH, v);
        chk("read lock", v, 8'hfc);
        $display("test lock done");
    endtask
    task automatic t_sig();
        logic [7:0] v;
        logic [7:0] sig [3] = '{8'h5a, 8'h3c, 8'h0f};
        prog.ld(ACT_CMD, 2'h0, CMD_READ_SIG);
        for (int i = 0; i < 4; i++) begin
            prog.ld(ACT_ADDR, BSEL_LOW, i[7:0]);
            prog.rd(2'h0, v);
            chk("signature", v, i < 3 ? sig[i] : ERASED_BYTE);
        end
        prog.ld(ACT_ADDR, BSEL_LOW, CALIB_ADDR);
        prog.rd(2'h1, v);
        chk("calibration", v, 8'h80);
        $display("test signature done");
    endtask
    initial begin
        repeat (4) @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        chk("reset fuse low", fuse_low, FUSE_LOW_RESET);
        chk("reset fuse high", fuse_high, FUSE_HIGH_RESET);
        chk("reset fuse ext", fuse_ext, FUSE_EXT_RESET);
        chk("reset lock", lock_bits, LOCK_RESET);
        chk("reset ready", {6'h0, done_flag, data_oe}, 8'h02);
        t_flash();
        t_ee();
        t_fuse();
        t_lock();
        t_sig();
        end_sim();
    end
endmodule
